//--- rtl/rtam_pkg.sv
// Package for the remote terminal address map and first configuration register
package rtam_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int REG_COUNT = 32;
    localparam logic [14:0] REG_LAST = 15'h001F;
    localparam logic [14:0] RAM_FIRST = 15'h0020;
    localparam logic [14:0] RAM_LAST = 15'h7FFF;
    localparam int RAM_DEPTH = 32768;
    localparam logic [4:0] OFF_CONFIG_ONE = 5'h00;
    localparam logic [4:0] OFF_CONFIG_TWO = 5'h01;
    localparam logic [4:0] OFF_OPERATIONAL_STATUS = 5'h02;
    localparam logic [4:0] OFF_CURRENT_COMMAND = 5'h03;
    localparam logic [4:0] OFF_CURRENT_CONTROL_WORD_ADDR = 5'h04;
    localparam logic [4:0] OFF_DESCRIPTOR_TABLE_BASE = 5'h05;
    localparam logic [4:0] OFF_PENDING_INTERRUPTS = 5'h06;
    localparam logic [4:0] OFF_STATUS_WORD_BITS = 5'h07;
    localparam logic [4:0] OFF_TIME_TAG_VALUE = 5'h08;
    localparam logic [4:0] OFF_INTERRUPT_LOG_POINTER = 5'h09;
    localparam logic [4:0] OFF_CURRENT_MSG_INFO_ADDR = 5'h0A;
    localparam logic [4:0] OFF_SERIAL_MEMORY_POINTER = 5'h0F;
    localparam logic [4:0] OFF_INTERRUPT_ENABLES = 5'h10;
    localparam logic [4:0] OFF_TIME_TAG_UTILITY = 5'h11;
    localparam logic [4:0] OFF_BUS_A_SELECT_VALUE = 5'h12;
    localparam logic [4:0] OFF_BUS_B_SELECT_VALUE = 5'h13;
    localparam logic [4:0] OFF_SELF_TEST_WORD = 5'h14;
    localparam logic [4:0] OFF_ALT_SELF_TEST_WORD = 5'h15;
    localparam logic [4:0] OFF_TEST_CONTROL = 5'h17;
    localparam logic [4:0] OFF_LOOPBACK_TX_DATA = 5'h18;
    localparam logic [4:0] OFF_LOOPBACK_RX_DATA = 5'h19;
    // Config one fields
    localparam int BIT_BUS_A_DISABLE = 15;
    localparam int BIT_BUS_B_DISABLE = 14;
    localparam int BIT_IRQ_STYLE = 13;
    localparam int BIT_SHUTDOWN_SCOPE = 12;
    localparam int BIT_TT_SEL_HI = 11;
    localparam int BIT_TT_SEL_LO = 9;
    localparam int BIT_RUN_ENABLE = 8;
    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_BROADCAST_IGNORE = 4;
    localparam int BIT_UNDEF_MC_IGNORE = 3;
    localparam logic [15:0] CFG1_WMASK = 16'hFF9F;
    localparam logic [15:0] CFG1_RESET = 16'h0000;
    // Config two manual shutdown option
    localparam int BIT_MANUAL_SHUTDOWN = 9;
    // Operational status fields
    localparam int OPS_ADDR_LO = 0;
    localparam int OPS_PARITY = 5;
    localparam int OPS_LOCK = 6;
    localparam int OPS_PARITY_FAULT = 7;
    localparam logic [15:0] OPS_WMASK = 16'h003F;
    localparam int PIR_PARITY_FAULT = 0;
    localparam logic [15:0] SELF_TEST_WMASK = 16'h0FFF;
    localparam logic [4:0] BROADCAST_ADDR = 5'h1F;
    // Time tag
    localparam int CLK_HZ = 20_000_000;
    localparam int TT_BASE_NS = 2000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int TT_BASE_CYC = (TT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] TT_OFF = 3'h0;
    localparam logic [2:0] TT_EXT = 3'h1;
    typedef struct packed {
        logic bus_a_disable;
        logic bus_b_disable;
        logic irq_style_select;
        logic shutdown_scope_select;
        logic [2:0] timetag_clk_sel;
        logic run_enable;
        logic soft_reset_request;
        logic [1:0] unused;
        logic broadcast_ignore;
        logic undefined_modecode_ignore;
        logic [2:0] low_bits;
    } rtam_cfg1_s;
    typedef struct packed {
        logic bus_a_tx_en;
        logic bus_a_rx_en;
        logic bus_b_tx_en;
        logic bus_b_rx_en;
    } rtam_bus_en_s;
    typedef enum logic [1:0] {
        SOFT_RESET_REQUEST_IDLE,
        SOFT_RESET_REQUEST_CLEAR,
        SOFT_RESET_REQUEST_DONE
    } rtam_soft_reset_request_e;
endpackage

//--- rtl/rtam_top.sv
// Address decode, register bank, shared RAM and first configuration register
// Contract
// RULE_01: Every location is reached by a 15-bit word address.
// RULE_02: Word addresses 0x0000 to 0x001F decode to registers, accessed like RAM.
// RULE_03: Addresses 0x0020 to 0x7FFF are RAM shared by host and device.
// RULE_04: Host writes never alter read-only registers or read-only fields.
// RULE_05: Simultaneous host and device writes to one word are arbitrated cleanly.
// RULE_06: Master reset zeroes all register bits except pin mirrors; bit 15 MSB.
// RULE_07: Master reset clears config one; soft reset clears only its request bit.
// RULE_08: Bit 15 disables bus A; its transmitter also off by inhibit pin.
// RULE_09: Bit 14 disables bus B; its transmitter also off by inhibit pin.
// RULE_10: Bit 13 low gives pulse interrupts, high gives level until acknowledged.
// RULE_11: Scope zero with automatic shutdown: shutdown disables inactive transmitter and receiver.
// RULE_12: Scope one with automatic shutdown: shutdown disables only inactive transmitter.
// RULE_13: Bits 11 to 9 pick time-tag clock: off, external, 2us to 64us.
// RULE_14: Bit 8 set starts terminal operation; clear halts it.
// RULE_15: Address parity fault blocks operation and sets status and pending flags.
// RULE_16: Writing bit 7 starts soft reset at once; the bit self-clears.
// RULE_17: Host must not request soft reset during self-initialization.
// RULE_18: Bit 4 high ignores terminal address 31; low treats it as broadcast.
// RULE_19: Bit 3 covers only the listed undefined mode codes and direction.
// RULE_20: Bit 3 low: undefined codes follow illegalization, illegal gives error status.
// RULE_21: Bit 3 high: undefined codes get no recognition, response or status.
// RULE_22: Address, parity and lock pins latch at master reset release only.
// RULE_23: With manual shutdown option clear, device performs shutdown and override itself.
// RULE_24: Reserved addresses and unused bits 6 and 5 read zero, ignore writes.
`timescale 1ns/1ps
module rtam_top (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_MASTER_RESET_N,
    input wire logic I_HOST_RD,
    input wire logic I_HOST_WR,
    input wire logic [14:0] I_HOST_ADDR,
    input wire logic [15:0] I_HOST_WDATA,
    input wire logic I_DEV_WR,
    input wire logic [14:0] I_DEV_ADDR,
    input wire logic [15:0] I_DEV_WDATA,
    input wire logic [15:0] I_DEV_WMASK,
    input wire logic [4:0] I_TERMINAL_ADDRESS_PINS,
    input wire logic I_TERMINAL_ADDRESS_PARITY_PIN,
    input wire logic I_LOCK_PIN,
    input wire logic I_BUS_A_TX_INHIBIT_PIN,
    input wire logic I_BUS_B_TX_INHIBIT_PIN,
    input wire logic I_TIMETAG_EXT_CLOCK_IN,
    input wire logic I_IRQ_MSG_EVENT,
    input wire logic I_IRQ_HW_EVENT,
    input wire logic I_IRQ_ACK,
    input wire logic I_SHUTDOWN_CMD,
    input wire logic I_OVERRIDE_CMD,
    input wire logic I_ACTIVE_BUS_B,
    input wire logic [4:0] I_CMD_ADDR,
    input wire logic I_CMD_TX,
    input wire logic [4:0] I_CMD_MODECODE,
    input wire logic I_CMD_IS_MODE,
    output logic O_HOST_RVALID,
    output logic [15:0] O_HOST_RDATA,
    output logic O_BUS_A_TX_EN,
    output logic O_BUS_A_RX_EN,
    output logic O_BUS_B_TX_EN,
    output logic O_BUS_B_RX_EN,
    output logic O_MESSAGE_IRQ_OUT,
    output logic O_HARDWARE_IRQ_OUT,
    output logic O_TERMINAL_RUN,
    output logic O_TIMETAG_TICK,
    output logic O_SOFT_RESET_PULSE,
    output logic O_CMD_ACCEPT,
    output logic O_UNDEF_MC_INVALID
);
    logic [15:0] regs_ff [0:31];
    logic [15:0] ram_ff [0:32767];
    logic [15:0] nxt_reg_val [0:31];
    logic [15:0] cfg1;
    rtam_pkg::rtam_cfg1_s cfg1_f;
    logic mr_q_ff;
    logic mr_rise;
    logic parity_fault;
    logic host_reg_wr;
    logic dev_reg_wr;
    logic [4:0] host_idx;
    logic [4:0] dev_idx;
    rtam_pkg::rtam_soft_reset_request_e soft_reset_request_state_ff;
    logic shut_a_ff;
    logic shut_b_ff;
    logic ext_q_ff;
    logic [7:0] tt_div_ff;
    logic [5:0] tt_pre_ff;
    logic tt_base_tick;
    logic [2:0] tt_sel;

    function automatic logic is_reg(input logic [14:0] a);
        is_reg = (a <= rtam_pkg::REG_LAST); // RULE_02
    endfunction

    function automatic logic [15:0] host_mask(input logic [4:0] idx);
        if (idx == rtam_pkg::OFF_CONFIG_ONE) begin
            host_mask = rtam_pkg::CFG1_WMASK; // RULE_24
        end else if (idx == rtam_pkg::OFF_OPERATIONAL_STATUS) begin
            host_mask = regs_ff[rtam_pkg::OFF_OPERATIONAL_STATUS][rtam_pkg::OPS_LOCK] ?
                16'h0000 : rtam_pkg::OPS_WMASK; // RULE_04
        end else if (idx == rtam_pkg::OFF_SELF_TEST_WORD) begin
            host_mask = rtam_pkg::SELF_TEST_WMASK; // RULE_04
        end else if (idx == rtam_pkg::OFF_CONFIG_TWO || idx == rtam_pkg::OFF_DESCRIPTOR_TABLE_BASE
            || idx == rtam_pkg::OFF_STATUS_WORD_BITS || idx == rtam_pkg::OFF_SERIAL_MEMORY_POINTER
            || (idx >= rtam_pkg::OFF_INTERRUPT_ENABLES && idx <= rtam_pkg::OFF_BUS_B_SELECT_VALUE)
            || idx == rtam_pkg::OFF_ALT_SELF_TEST_WORD || idx == rtam_pkg::OFF_TEST_CONTROL
            || idx == rtam_pkg::OFF_LOOPBACK_TX_DATA) begin
            host_mask = 16'hFFFF;
        end else begin
            host_mask = 16'h0000; // RULE_04 RULE_24
        end
    endfunction

    assign cfg1 = regs_ff[rtam_pkg::OFF_CONFIG_ONE];
    assign cfg1_f = rtam_pkg::rtam_cfg1_s'(cfg1);
    assign host_idx = I_HOST_ADDR[4:0]; // RULE_01
    assign dev_idx = I_DEV_ADDR[4:0];
    assign host_reg_wr = I_HOST_WR && is_reg(I_HOST_ADDR);
    assign dev_reg_wr = I_DEV_WR && is_reg(I_DEV_ADDR);
    assign mr_rise = I_MASTER_RESET_N && !mr_q_ff;
    assign parity_fault = ~^regs_ff[rtam_pkg::OFF_OPERATIONAL_STATUS][5:0]; // RULE_15
    assign tt_sel = cfg1_f.timetag_clk_sel;

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            mr_q_ff <= 1'b0;
        end else begin
            mr_q_ff <= I_MASTER_RESET_N;
        end
    end

    // Merge of host and device writes per bit
    always_comb begin
        for (int i = 0; i < rtam_pkg::REG_COUNT; i++) begin
            nxt_reg_val[i] = regs_ff[i];
            if (dev_reg_wr && dev_idx == 5'(i)) begin
                nxt_reg_val[i] = (nxt_reg_val[i] & ~I_DEV_WMASK) | (I_DEV_WDATA & I_DEV_WMASK);
            end
            if (host_reg_wr && host_idx == 5'(i)) begin
                // RULE_05: device-owned bits keep the device value
                nxt_reg_val[i] = (nxt_reg_val[i] & ~(host_mask(5'(i)) & ~I_DEV_WMASK
                    | (dev_reg_wr && dev_idx == 5'(i) ? 16'h0000 : host_mask(5'(i)))))
                    | (I_HOST_WDATA & host_mask(5'(i))
                    & ~(dev_reg_wr && dev_idx == 5'(i) ? I_DEV_WMASK : 16'h0000));
            end
        end
        if (soft_reset_request_state_ff == rtam_pkg::SOFT_RESET_REQUEST_CLEAR) begin
            nxt_reg_val[rtam_pkg::OFF_CONFIG_ONE][rtam_pkg::BIT_SOFT_RESET] = 1'b0; // RULE_07 RULE_16
        end
        if (parity_fault && !mr_rise) begin
            nxt_reg_val[rtam_pkg::OFF_OPERATIONAL_STATUS][rtam_pkg::OPS_PARITY_FAULT] = 1'b1; // RULE_15
            nxt_reg_val[rtam_pkg::OFF_PENDING_INTERRUPTS][rtam_pkg::PIR_PARITY_FAULT] = 1'b1; // RULE_15
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || !I_MASTER_RESET_N) begin
            for (int i = 0; i < rtam_pkg::REG_COUNT; i++) begin
                regs_ff[i] <= 16'h0000; // RULE_06 RULE_07
            end
        end else begin
            for (int i = 0; i < rtam_pkg::REG_COUNT; i++) begin
                regs_ff[i] <= nxt_reg_val[i];
            end
            if (mr_rise) begin
                regs_ff[rtam_pkg::OFF_OPERATIONAL_STATUS][6:0] <= {I_LOCK_PIN,
                    I_TERMINAL_ADDRESS_PARITY_PIN, I_TERMINAL_ADDRESS_PINS}; // RULE_22
            end
        end
    end

    // Shared RAM; a colliding device write wins only on its masked bits, the host writes the rest
    always_ff @(posedge I_REF_CLK) begin
        if (I_DEV_WR && !is_reg(I_DEV_ADDR)) begin
            ram_ff[I_DEV_ADDR] <= (ram_ff[I_DEV_ADDR] & ~I_DEV_WMASK)
                | (I_DEV_WDATA & I_DEV_WMASK); // RULE_03
        end
        if (I_HOST_WR && !is_reg(I_HOST_ADDR)
            && !(I_DEV_WR && I_DEV_ADDR == I_HOST_ADDR)) begin
            ram_ff[I_HOST_ADDR] <= I_HOST_WDATA; // RULE_03
        end else if (I_HOST_WR && !is_reg(I_HOST_ADDR) && I_DEV_WR) begin
            ram_ff[I_HOST_ADDR] <= (I_HOST_WDATA & ~I_DEV_WMASK)
                | (I_DEV_WDATA & I_DEV_WMASK); // RULE_05
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_HOST_RVALID <= 1'b0;
            O_HOST_RDATA <= 16'h0000;
        end else begin
            O_HOST_RVALID <= I_HOST_RD;
            if (!I_HOST_RD) begin
                O_HOST_RDATA <= 16'h0000;
            end else if (is_reg(I_HOST_ADDR)) begin
                O_HOST_RDATA <= regs_ff[host_idx]; // RULE_02 RULE_24
            end else begin
                O_HOST_RDATA <= ram_ff[I_HOST_ADDR]; // RULE_03
            end
        end
    end

    // Soft reset sequencer
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || !I_MASTER_RESET_N) begin
            soft_reset_request_state_ff <= rtam_pkg::SOFT_RESET_REQUEST_IDLE;
            O_SOFT_RESET_PULSE <= 1'b0;
        end else begin
            O_SOFT_RESET_PULSE <= 1'b0;
            case (soft_reset_request_state_ff)
                rtam_pkg::SOFT_RESET_REQUEST_IDLE: begin
                    if (cfg1_f.soft_reset_request) begin
                        soft_reset_request_state_ff <= rtam_pkg::SOFT_RESET_REQUEST_CLEAR; // RULE_16
                        O_SOFT_RESET_PULSE <= 1'b1;
                    end
                end
                rtam_pkg::SOFT_RESET_REQUEST_CLEAR: begin
                    soft_reset_request_state_ff <= rtam_pkg::SOFT_RESET_REQUEST_DONE;
                end
                default: begin
                    soft_reset_request_state_ff <= rtam_pkg::SOFT_RESET_REQUEST_IDLE;
                end
            endcase
        end
    end

    // Automatic shutdown state of the inactive bus
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || !I_MASTER_RESET_N || O_SOFT_RESET_PULSE) begin
            shut_a_ff <= 1'b0;
            shut_b_ff <= 1'b0;
        end else if (!regs_ff[rtam_pkg::OFF_CONFIG_TWO][rtam_pkg::BIT_MANUAL_SHUTDOWN]) begin
            if (I_SHUTDOWN_CMD) begin
                if (I_ACTIVE_BUS_B) begin
                    shut_a_ff <= 1'b1; // RULE_23
                end else begin
                    shut_b_ff <= 1'b1; // RULE_23
                end
            end else if (I_OVERRIDE_CMD) begin
                if (I_ACTIVE_BUS_B) begin
                    shut_a_ff <= 1'b0; // RULE_23
                end else begin
                    shut_b_ff <= 1'b0; // RULE_23
                end
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_BUS_A_TX_EN <= 1'b0;
            O_BUS_A_RX_EN <= 1'b0;
            O_BUS_B_TX_EN <= 1'b0;
            O_BUS_B_RX_EN <= 1'b0;
            O_TERMINAL_RUN <= 1'b0;
        end else begin
            O_BUS_A_TX_EN <= !(cfg1_f.bus_a_disable || I_BUS_A_TX_INHIBIT_PIN || shut_a_ff); // RULE_08 RULE_12
            O_BUS_A_RX_EN <= !(cfg1_f.bus_a_disable
                || (shut_a_ff && !cfg1_f.shutdown_scope_select)); // RULE_08 RULE_11
            O_BUS_B_TX_EN <= !(cfg1_f.bus_b_disable || I_BUS_B_TX_INHIBIT_PIN || shut_b_ff); // RULE_09 RULE_12
            O_BUS_B_RX_EN <= !(cfg1_f.bus_b_disable
                || (shut_b_ff && !cfg1_f.shutdown_scope_select)); // RULE_09 RULE_11
            O_TERMINAL_RUN <= cfg1_f.run_enable && !parity_fault && I_MASTER_RESET_N; // RULE_14 RULE_15
        end
    end

    // Interrupt pin style
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || !I_MASTER_RESET_N) begin
            O_MESSAGE_IRQ_OUT <= 1'b0;
            O_HARDWARE_IRQ_OUT <= 1'b0;
        end else if (!cfg1_f.irq_style_select) begin
            O_MESSAGE_IRQ_OUT <= I_IRQ_MSG_EVENT; // RULE_10
            O_HARDWARE_IRQ_OUT <= I_IRQ_HW_EVENT; // RULE_10
        end else begin
            O_MESSAGE_IRQ_OUT <= I_IRQ_MSG_EVENT || (O_MESSAGE_IRQ_OUT && !I_IRQ_ACK); // RULE_10
            O_HARDWARE_IRQ_OUT <= I_IRQ_HW_EVENT || (O_HARDWARE_IRQ_OUT && !I_IRQ_ACK); // RULE_10
        end
    end

    // Time tag tick source
    assign tt_base_tick = (tt_div_ff == 8'(rtam_pkg::TT_BASE_CYC - 1));
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || !I_MASTER_RESET_N) begin
            tt_div_ff <= 8'h00;
            tt_pre_ff <= 6'h00;
            ext_q_ff <= 1'b0;
            O_TIMETAG_TICK <= 1'b0;
        end else begin
            ext_q_ff <= I_TIMETAG_EXT_CLOCK_IN;
            tt_div_ff <= tt_base_tick ? 8'h00 : tt_div_ff + 8'h01;
            if (tt_base_tick) begin
                tt_pre_ff <= tt_pre_ff + 6'h01;
            end
            if (tt_sel == rtam_pkg::TT_OFF) begin
                O_TIMETAG_TICK <= 1'b0; // RULE_13
            end else if (tt_sel == rtam_pkg::TT_EXT) begin
                O_TIMETAG_TICK <= I_TIMETAG_EXT_CLOCK_IN && !ext_q_ff; // RULE_13
            end else begin
                // Period doubles per step from 2us
                O_TIMETAG_TICK <= tt_base_tick
                    && ((tt_pre_ff & ((6'h01 << (tt_sel - 3'h2)) - 6'h01)) == 6'h00); // RULE_13
            end
        end
    end

    // Command qualification for address 31 and undefined mode codes
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_CMD_ACCEPT <= 1'b0;
            O_UNDEF_MC_INVALID <= 1'b0;
        end else begin
            O_CMD_ACCEPT <= !(cfg1_f.broadcast_ignore
                && I_CMD_ADDR == rtam_pkg::BROADCAST_ADDR); // RULE_18
            O_UNDEF_MC_INVALID <= cfg1_f.undefined_modecode_ignore && I_CMD_IS_MODE
                && ((!I_CMD_TX && (I_CMD_MODECODE <= 5'h10 || I_CMD_MODECODE == 5'h12
                || I_CMD_MODECODE == 5'h13)) || (I_CMD_TX && (I_CMD_MODECODE == 5'h11
                || I_CMD_MODECODE == 5'h14 || I_CMD_MODECODE == 5'h15))); // RULE_19 RULE_20 RULE_21
        end
    end

    // Assertions
    soft_reset_request_clears_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST || !I_MASTER_RESET_N)
        soft_reset_request_state_ff == rtam_pkg::SOFT_RESET_REQUEST_CLEAR ##1 !I_HOST_WR [*1] |-> !cfg1[rtam_pkg::BIT_SOFT_RESET])
        else $error("soft reset bit did not self clear"); // RULE_16
    bus_a_tx_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_BUS_A_TX_INHIBIT_PIN |=> !O_BUS_A_TX_EN)
        else $error("bus A transmitter not inhibited"); // RULE_08
    bus_b_tx_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        cfg1_f.bus_b_disable |=> !O_BUS_B_TX_EN && !O_BUS_B_RX_EN)
        else $error("bus B not disabled"); // RULE_09
    run_parity_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        parity_fault |=> !O_TERMINAL_RUN)
        else $error("run despite parity fault"); // RULE_15
    bcast_ignore_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        cfg1_f.broadcast_ignore && I_CMD_ADDR == 5'h1F |=> !O_CMD_ACCEPT)
        else $error("broadcast accepted while ignored"); // RULE_18
    rsvd_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        I_HOST_RD && I_HOST_ADDR == 15'h000B |=> O_HOST_RDATA == 16'h0000)
        else $error("reserved register not zero"); // RULE_24
    cfg_unused_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
        cfg1[6:5] == 2'b00)
        else $error("unused config bits set"); // RULE_24
    level_irq_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST || !I_MASTER_RESET_N)
        cfg1_f.irq_style_select && O_MESSAGE_IRQ_OUT && !I_IRQ_ACK ##0 $stable(cfg1) |=>
        O_MESSAGE_IRQ_OUT)
        else $error("level interrupt dropped without ack"); // RULE_10
    run_cover_c: cover property (@(posedge I_REF_CLK) disable iff (I_RST) $rose(O_TERMINAL_RUN));
    soft_reset_request_cover_c: cover property (@(posedge I_REF_CLK) disable iff (I_RST) O_SOFT_RESET_PULSE);
    shut_cover_c: cover property (@(posedge I_REF_CLK) disable iff (I_RST) $fell(O_BUS_B_TX_EN));
endmodule // rtam_top

//--- dv/rtam_host_model.sv
// Host processor model driving the word-addressed register and RAM port
`timescale 1ns/1ps
module rtam_host_model (
    input wire logic i_clk,
    input wire logic i_rvalid,
    input wire logic [15:0] i_rdata,
    output logic o_rd,
    output logic o_wr,
    output logic [14:0] o_addr,
    output logic [15:0] o_wdata
);
    initial begin
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_addr = 15'h0000;
        o_wdata = 16'h0000;
    end
    // Word write, one-cycle strobe
    task automatic write(input logic [14:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // Word read, data taken with the valid pulse
    task automatic read(input logic [14:0] a, output logic [15:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        d = 16'hDEAD;
        repeat (4) begin
            @(posedge i_clk);
            if (i_rvalid === 1'b1) begin
                d = i_rdata;
                break;
            end
        end
    endtask
endmodule // rtam_host_model

//--- dv/rt_address_map_and_config_bench.sv
// Self-checking bench for the address map and first configuration register
`timescale 1ns/1ps
module rt_address_map_and_config_bench;
    logic clk = 1'b0, rst = 1'b1, mr_n = 1'b0, inh_a = 1'b0, inh_b = 1'b0, ev = 1'b0, ack = 1'b0;
    logic rd, wr, rv, txa, rxa, txb, rxb, mirq, run, tick, srp, acc, umc;
    logic dw = 1'b0, sd = 1'b0, tpar = 1'b0, ctx = 1'b0, cim = 1'b0;
    logic [4:0] tap = 5'h01, ca = 5'h00, cmc = 5'h00;
    logic [14:0] dad = 15'h0000;
    logic [15:0] dwd = 16'h0000, dwm = 16'h0000;
    logic [14:0] ad;
    logic [15:0] wd, rdat, v;
    int err_count = 0, checked = 0, cyc = 0, n;
    rtam_host_model host (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_rd(rd), .o_wr(wr),
        .o_addr(ad), .o_wdata(wd));
    rtam_top dut (.I_REF_CLK(clk), .I_RST(rst), .I_MASTER_RESET_N(mr_n), .I_HOST_RD(rd),
        .I_HOST_WR(wr), .I_HOST_ADDR(ad), .I_HOST_WDATA(wd), .I_DEV_WR(dw),
        .I_DEV_ADDR(dad), .I_DEV_WDATA(dwd), .I_DEV_WMASK(dwm),
        .I_TERMINAL_ADDRESS_PINS(tap), .I_TERMINAL_ADDRESS_PARITY_PIN(tpar), .I_LOCK_PIN(1'b0),
        .I_BUS_A_TX_INHIBIT_PIN(inh_a), .I_BUS_B_TX_INHIBIT_PIN(inh_b),
        .I_TIMETAG_EXT_CLOCK_IN(1'b0), .I_IRQ_MSG_EVENT(ev), .I_IRQ_HW_EVENT(1'b0),
        .I_IRQ_ACK(ack), .I_SHUTDOWN_CMD(sd), .I_OVERRIDE_CMD(1'b0), .I_ACTIVE_BUS_B(1'b0),
        .I_CMD_ADDR(ca), .I_CMD_TX(ctx), .I_CMD_MODECODE(cmc), .I_CMD_IS_MODE(cim),
        .O_HOST_RVALID(rv), .O_HOST_RDATA(rdat), .O_BUS_A_TX_EN(txa), .O_BUS_A_RX_EN(rxa),
        .O_BUS_B_TX_EN(txb), .O_BUS_B_RX_EN(rxb), .O_MESSAGE_IRQ_OUT(mirq),
        .O_HARDWARE_IRQ_OUT(), .O_TERMINAL_RUN(run), .O_TIMETAG_TICK(tick),
        .O_SOFT_RESET_PULSE(srp), .O_CMD_ACCEPT(acc), .O_UNDEF_MC_INVALID(umc));
    initial forever #25 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [14:0] a, input logic [15:0] exp);
        host.read(a, v);
        check(v, exp);
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test;
        end
    end
    task automatic t_reset;
        rd_chk(15'h0000, 16'h0000);
        rd_chk(15'h0002, 16'h0001);
        rd_chk(15'h000B, 16'h0000);
        rd_chk(15'h001F, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_cfg;
        host.write(15'h0000, 16'hFF7F);
        rd_chk(15'h0000, 16'hFF1F);
        check({12'h000, txa, rxa, txb, rxb}, 16'h0000);
        check({15'h0000, run}, 16'h0001);
        host.write(15'h0000, 16'h0000);
        rd_chk(15'h0000, 16'h0000);
        check({11'h000, run, txa, rxa, txb, rxb}, 16'h000F);
        $display("config test done");
    endtask
    task automatic t_soft_reset_request;
        host.write(15'h0000, 16'h0180);
        n = 0;
        repeat (6) begin
            @(posedge clk);
            if (srp === 1'b1) n = 1;
        end
        check(n[15:0], 16'h0001);
        rd_chk(15'h0000, 16'h0100);
        host.write(15'h0000, 16'h0000);
        $display("soft reset test done");
    endtask
    task automatic t_pins;
        @(posedge clk) inh_a <= 1'b1;
        repeat (3) @(posedge clk);
        check({12'h000, txa, rxa, txb, rxb}, 16'h0007);
        inh_a <= 1'b0;
        inh_b <= 1'b1;
        repeat (3) @(posedge clk);
        check({12'h000, txa, rxa, txb, rxb}, 16'h000D);
        inh_b <= 1'b0;
        $display("inhibit pin test done");
    endtask
    task automatic t_mem;
        host.write(15'h0020, 16'hA5A5);
        host.write(15'h7FFF, 16'h5A5A);
        host.write(15'h0006, 16'hFFFF);
        rd_chk(15'h0020, 16'hA5A5);
        rd_chk(15'h7FFF, 16'h5A5A);
        rd_chk(15'h0006, 16'h0000);
        $display("memory test done");
    endtask
    task automatic t_tt;
        for (int s = 2; s < 4; s++) begin
            host.write(15'h0000, 16'(s << 9));
            repeat (2) @(posedge clk);
            n = 0;
            while (tick !== 1'b1 && n < 200) begin
                @(posedge clk);
                n++;
            end
            @(posedge clk);
            n = 1;
            while (tick !== 1'b1 && n < 200) begin
                @(posedge clk);
                n++;
            end
            check(n[15:0], 16'(40 << (s - 2)));
        end
        host.write(15'h0000, 16'h0000);
        $display("time tag test done");
    endtask
    task automatic t_irq;
        for (int m = 0; m < 2; m++) begin
            host.write(15'h0000, m[0] ? 16'h2000 : 16'h0000);
            @(posedge clk) ev <= 1'b1;
            @(posedge clk) ev <= 1'b0;
            n = 0;
            while (mirq !== 1'b1 && n < 4) begin
                @(posedge clk);
                n++;
            end
            repeat (3) @(posedge clk);
            check({15'h0000, mirq}, {15'h0000, m[0]});
            @(posedge clk) ack <= 1'b1;
            @(posedge clk) ack <= 1'b0;
            repeat (3) @(posedge clk);
            check({15'h0000, mirq}, 16'h0000);
        end
        $display("interrupt test done");
    endtask
    task automatic t_ext;
        fork
            host.write(15'h0030, 16'h1234);
            begin
                @(posedge clk);
                dw <= 1'b1;
                dad <= 15'h0030;
                dwd <= 16'hABCD;
                dwm <= 16'hFF00;
                @(posedge clk);
                dw <= 1'b0;
            end
        join
        rd_chk(15'h0030, 16'hAB34);
        host.write(15'h0000, 16'h0018);
        @(posedge clk) ca <= 5'h1F;
        cim <= 1'b1;
        cmc <= 5'h02;
        repeat (2) @(posedge clk);
        check({14'h0000, acc, umc}, 16'h0001);
        cmc <= 5'h11;
        repeat (2) @(posedge clk);
        check({14'h0000, acc, umc}, 16'h0000);
        host.write(15'h0000, 16'h0000);
        repeat (2) @(posedge clk);
        check({14'h0000, acc, umc}, 16'h0002);
        @(posedge clk) sd <= 1'b1;
        @(posedge clk) sd <= 1'b0;
        repeat (2) @(posedge clk);
        check({12'h000, txa, rxa, txb, rxb}, 16'h000C);
        host.write(15'h0000, 16'h1000);
        repeat (2) @(posedge clk);
        check({12'h000, txa, rxa, txb, rxb}, 16'h000D);
        host.write(15'h0000, 16'h1080);
        repeat (4) @(posedge clk);
        check({12'h000, txa, rxa, txb, rxb}, 16'h000F);
        @(posedge clk) mr_n <= 1'b0;
        tap <= 5'h02;
        tpar <= 1'b1;
        repeat (3) @(posedge clk);
        mr_n <= 1'b1;
        repeat (2) @(posedge clk);
        host.write(15'h0000, 16'h0100);
        rd_chk(15'h0002, 16'h00A2);
        rd_chk(15'h0006, 16'h0001);
        check({15'h0000, run}, 16'h0000);
        @(posedge clk) mr_n <= 1'b0;
        tap <= 5'h01;
        tpar <= 1'b0;
        repeat (3) @(posedge clk);
        mr_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd_chk(15'h0002, 16'h0001);
        $display("extended test done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        mr_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset;
        t_cfg;
        t_soft_reset_request;
        t_pins;
        t_mem;
        t_tt;
        t_irq;
        t_ext;
        finish_test;
    end
endmodule // rt_address_map_and_config_bench
